//--- shared/ldcr_pkg.sv
package ldcr_pkg;

   // ==========================================================
   // serial link
   // ==========================================================
   localparam logic [6:0] SLAVE_ADDR     = 7'h77;
   localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
   localparam logic [3:0] ACK_SLOT       = 4'h9;

   // ==========================================================
   // register offsets
   // ==========================================================
   localparam logic [7:0] OFS_SENSE_LEVEL     = 8'h00;
   localparam logic [7:0] OFS_RAMP_PEAK       = 8'h01;
   localparam logic [7:0] OFS_FOLDBACK_THRESH = 8'h02;
   localparam logic [7:0] OFS_KNEE_POINT      = 8'h03;
   localparam logic [7:0] OFS_SLOPE_GAIN      = 8'h04;
   localparam logic [7:0] OFS_CLAMP_LEVEL     = 8'h05;
   localparam logic [7:0] OFS_NVM_LOAD        = 8'h06;
   localparam logic [7:0] OFS_NVM_PROGRAM     = 8'h08;
   localparam logic [7:0] OFS_UNLOCK_KEY      = 8'hFF;
   localparam logic [7:0] OFS_LAST_AUTOINC    = 8'h05;
   localparam logic [7:0] UNLOCK_VALUE        = 8'hCA;

   // ==========================================================
   // field widths as masks
   // ==========================================================
   localparam logic [3:0] MASK_SENSE_LEVEL     = 4'hF;
   localparam logic [3:0] MASK_RAMP_PEAK       = 4'h7;
   localparam logic [3:0] MASK_FOLDBACK_THRESH = 4'hF;
   localparam logic [3:0] MASK_KNEE_POINT      = 4'hF;
   localparam logic [3:0] MASK_SLOPE_GAIN      = 4'h3;
   localparam logic [3:0] MASK_CLAMP_LEVEL     = 4'h7;

   // ==========================================================
   // factory values: field codes held in nonvolatile memory after reset, plus decoded output reset values
   // ==========================================================
   localparam logic [3:0] DEF_SENSE_LEVEL     = 4'hF;
   localparam logic [3:0] DEF_RAMP_PEAK       = 4'h7;
   localparam logic [3:0] DEF_FOLDBACK_THRESH = 4'h0;
   localparam logic [3:0] DEF_KNEE_POINT      = 4'h0;
   localparam logic [3:0] DEF_SLOPE_GAIN      = 4'h3;
   localparam logic [3:0] DEF_CLAMP_LEVEL     = 4'h7;
   localparam logic [4:0] DEF_SLOPE_VPV       = 5'h04;
   localparam logic [6:0] DEF_CLAMP_PCT       = 7'h28;
   localparam logic [10:0] DEF_KNEE_MV        = 11'h496;

   localparam int         NUM_WORK_REGS       = 6;
   localparam logic [2:0] LAST_WORK_IDX       = 3'h5;

   typedef enum logic [4:0] {
      LINK_IDLE  = 5'h01,
      LINK_ADDR  = 5'h02,
      LINK_CMD   = 5'h04,
      LINK_WDATA = 5'h08,
      LINK_READ  = 5'h10
   } ldcr_link_type;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h1,
      SEQ_LOAD = 3'h2,
      SEQ_PROG = 3'h4
   } ldcr_seq_type;

endpackage

//--- rtl/ldcr_nvm.sv
`timescale 1ns/1ps
module ldcr_nvm (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wr_en,
   input  wire logic [2:0] wr_addr,
   input  wire logic [3:0] wr_data,
   input  wire logic [2:0] rd_addr,
   output logic      [3:0] rd_data
);

   logic [3:0] cell_reg [0:5];

   // ==========================================================
   // storage, read data registered
   // ==========================================================
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cell_reg[0] <= ldcr_pkg::DEF_SENSE_LEVEL;
         cell_reg[1] <= ldcr_pkg::DEF_RAMP_PEAK;
         cell_reg[2] <= ldcr_pkg::DEF_FOLDBACK_THRESH;
         cell_reg[3] <= ldcr_pkg::DEF_KNEE_POINT;
         cell_reg[4] <= ldcr_pkg::DEF_SLOPE_GAIN;
         cell_reg[5] <= ldcr_pkg::DEF_CLAMP_LEVEL;
         rd_data     <= 4'h0;
      end else begin
         if (wr_en && wr_addr <= ldcr_pkg::LAST_WORK_IDX) begin
            cell_reg[wr_addr] <= wr_data;
         end
         rd_data <= (rd_addr <= ldcr_pkg::LAST_WORK_IDX) ?
                    cell_reg[rd_addr] : 4'h0;
      end
   end

endmodule

//--- rtl/ldcr_top.sv
`timescale 1ns/1ps
module ldcr_top (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sensor_positive_clock_pin,
   input  wire logic        sensor_negative_data_pin_i,
   output logic             sensor_negative_data_pin_o,
   output logic             sensor_negative_data_pin_oe,
   input  wire logic [10:0] sensor_diff_mv,
   output logic      [3:0]  sense_level_code,
   output logic      [2:0]  ramp_peak_code,
   output logic      [3:0]  foldback_thresh_code,
   output logic      [3:0]  thermal_knee_code,
   output logic      [1:0]  slope_gain_code,
   output logic      [2:0]  clamp_level_code,
   output logic      [4:0]  slope_gain_vpv,
   output logic      [6:0]  clamp_percent,
   output logic      [10:0] knee_mv,
   output logic             thermal_dim_active,
   output logic             program_unlocked,
   output logic             nvm_busy
);

   // ==========================================================
   // decode functions
   function automatic logic [3:0] field_mask(input logic [2:0] idx);
      case (idx)
         3'h0:    field_mask = ldcr_pkg::MASK_SENSE_LEVEL;
         3'h1:    field_mask = ldcr_pkg::MASK_RAMP_PEAK;
         3'h2:    field_mask = ldcr_pkg::MASK_FOLDBACK_THRESH;
         3'h3:    field_mask = ldcr_pkg::MASK_KNEE_POINT;
         3'h4:    field_mask = ldcr_pkg::MASK_SLOPE_GAIN;
         default: field_mask = ldcr_pkg::MASK_CLAMP_LEVEL;
      endcase
   endfunction
   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      next_ptr = (p < ldcr_pkg::OFS_LAST_AUTOINC) ? p + 8'h01 : p;
   endfunction
   function automatic logic [10:0] knee_of(input logic [3:0] c);
      case (c)
         4'h0: knee_of = 11'h496;
         4'h1: knee_of = 11'h45E;
         4'h2: knee_of = 11'h426;
         4'h3: knee_of = 11'h3EE;
         4'h4: knee_of = 11'h3B6;
         4'h5: knee_of = 11'h37E;
         4'h6: knee_of = 11'h346;
         4'h7: knee_of = 11'h30E;
         4'h8: knee_of = 11'h2D6;
         4'h9: knee_of = 11'h29E;
         4'hA: knee_of = 11'h267;
         4'hB: knee_of = 11'h22F;
         4'hC: knee_of = 11'h1F7;
         4'hD: knee_of = 11'h1BF;
         4'hE: knee_of = 11'h187;
         default: knee_of = 11'h14F;
      endcase
   endfunction
   function automatic logic [6:0] clamp_of(input logic [2:0] c);
      case (c)
         3'h0: clamp_of = 7'h64;
         3'h1: clamp_of = 7'h5B;
         3'h2: clamp_of = 7'h53;
         3'h3: clamp_of = 7'h4A;
         3'h4: clamp_of = 7'h42;
         3'h5: clamp_of = 7'h39;
         3'h6: clamp_of = 7'h31;
         default: clamp_of = 7'h28;
      endcase
   endfunction

   // ==========================================================
   // pin synchronisers and edge detection
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic       scl_q_reg;
   logic       sda_q_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_q_reg    <= 1'b1;
         sda_q_reg    <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], sensor_positive_clock_pin};
         sda_sync_reg <= {sda_sync_reg[0], sensor_negative_data_pin_i};
         scl_q_reg    <= scl_sync_reg[1];
         sda_q_reg    <= sda_sync_reg[1];
      end
   end

   wire scl_s    = scl_sync_reg[1];
   wire sda_s    = sda_sync_reg[1];
   wire start_ev = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   wire stop_ev  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
   wire scl_rise = scl_s & ~scl_q_reg;
   wire scl_fall = ~scl_s & scl_q_reg;
   // ==========================================================
   // serial slave
   ldcr_pkg::ldcr_link_type link_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] ptr_reg;
   logic       sda_oe_reg;
   logic       master_ack_reg;
   logic       wr_stb_reg;
   logic [7:0] wr_addr_reg;
   logic [7:0] wr_data_reg;
   logic [3:0] work_reg [0:5];
   wire [7:0] rx_byte   = shift_reg;
   wire       byte_done = scl_fall && bit_cnt_reg == ldcr_pkg::BITS_PER_BYTE;
   wire       ack_done  = scl_fall && bit_cnt_reg == ldcr_pkg::ACK_SLOT;
   wire       addr_hit  = rx_byte[7:1] == ldcr_pkg::SLAVE_ADDR;
   wire [7:0] rd_value  = (ptr_reg <= ldcr_pkg::OFS_LAST_AUTOINC) ?
                          {4'h0, work_reg[ptr_reg[2:0]]} : 8'h00;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_reg       <= ldcr_pkg::LINK_IDLE;
         shift_reg      <= 8'h00;
         tx_reg         <= 8'h00;
         bit_cnt_reg    <= 4'h0;
         ptr_reg        <= 8'h00;
         sda_oe_reg     <= 1'b0;
         master_ack_reg <= 1'b0;
         wr_stb_reg     <= 1'b0;
         wr_addr_reg    <= 8'h00;
         wr_data_reg    <= 8'h00;
      end else begin
         wr_stb_reg <= 1'b0;
         if (start_ev) begin
            link_reg    <= ldcr_pkg::LINK_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
         end else if (stop_ev) begin
            link_reg    <= ldcr_pkg::LINK_IDLE;
            sda_oe_reg  <= 1'b0;
         end else if (link_reg != ldcr_pkg::LINK_IDLE) begin
            if (scl_rise) begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg >= ldcr_pkg::BITS_PER_BYTE) begin
                  master_ack_reg <= ~sda_s;
               end else if (link_reg != ldcr_pkg::LINK_READ) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
               end
            end
            if (byte_done) begin
               sda_oe_reg <= 1'b1;
               unique case (link_reg)
                  ldcr_pkg::LINK_ADDR: begin
                     if (!addr_hit) begin
                        link_reg   <= ldcr_pkg::LINK_IDLE;
                        sda_oe_reg <= 1'b0;
                     end else if (rx_byte[0]) begin
                        link_reg <= ldcr_pkg::LINK_READ;
                     end else begin
                        link_reg <= ldcr_pkg::LINK_CMD;
                     end
                  end
                  ldcr_pkg::LINK_CMD: begin
                     ptr_reg  <= rx_byte;
                     link_reg <= ldcr_pkg::LINK_WDATA;
                  end
                  ldcr_pkg::LINK_WDATA: begin
                     wr_stb_reg  <= 1'b1;
                     wr_addr_reg <= ptr_reg;
                     wr_data_reg <= rx_byte;
                     ptr_reg     <= next_ptr(ptr_reg);
                  end
                  ldcr_pkg::LINK_READ: begin
                     sda_oe_reg <= 1'b0;
                     ptr_reg    <= next_ptr(ptr_reg);
                  end
                  default: begin
                     link_reg   <= ldcr_pkg::LINK_IDLE;
                     sda_oe_reg <= 1'b0;
                  end
               endcase
            end else if (ack_done) begin
               bit_cnt_reg <= 4'h0;
               sda_oe_reg  <= 1'b0;
               if (link_reg == ldcr_pkg::LINK_READ) begin
                  // first byte after address, or master asked for more
                  if (shift_reg[0] || master_ack_reg) begin
                     tx_reg     <= {rd_value[6:0], 1'b0};
                     sda_oe_reg <= ~rd_value[7];
                  end else begin
                     link_reg <= ldcr_pkg::LINK_IDLE;
                  end
                  shift_reg[0] <= 1'b0;
                  master_ack_reg <= 1'b0;
               end
            end else if (scl_fall && link_reg == ldcr_pkg::LINK_READ) begin
               sda_oe_reg <= ~tx_reg[7];
               tx_reg     <= {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

   // ==========================================================
   // memory copy sequencer
   ldcr_pkg::ldcr_seq_type seq_reg;
   logic [2:0] seq_idx_reg;
   logic       ld_valid_reg;
   logic [2:0] ld_idx_reg;
   logic       unlock_reg;
   logic [3:0] nvm_rd_data;
   wire wr_work   = wr_stb_reg && wr_addr_reg <= ldcr_pkg::OFS_LAST_AUTOINC;
   wire hit_load  = wr_stb_reg && wr_addr_reg == ldcr_pkg::OFS_NVM_LOAD;
   wire hit_prog  = wr_stb_reg && wr_addr_reg == ldcr_pkg::OFS_NVM_PROGRAM;
   wire hit_key   = wr_stb_reg && wr_addr_reg == ldcr_pkg::OFS_UNLOCK_KEY;
   wire seq_last  = seq_idx_reg == ldcr_pkg::LAST_WORK_IDX;
   wire nvm_we    = seq_reg == ldcr_pkg::SEQ_PROG;
   wire seq_idle  = seq_reg == ldcr_pkg::SEQ_IDLE;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_reg      <= ldcr_pkg::SEQ_LOAD;
         seq_idx_reg  <= 3'h0;
         ld_valid_reg <= 1'b0;
         ld_idx_reg   <= 3'h0;
         unlock_reg   <= 1'b0;
      end else begin
         ld_valid_reg <= seq_reg == ldcr_pkg::SEQ_LOAD;
         ld_idx_reg   <= seq_idx_reg;
         if (hit_key) begin
            unlock_reg <= wr_data_reg == ldcr_pkg::UNLOCK_VALUE;
         end
         unique case (seq_reg)
            ldcr_pkg::SEQ_IDLE: begin
               seq_idx_reg <= 3'h0;
               if (hit_load) begin
                  seq_reg <= ldcr_pkg::SEQ_LOAD;
               end else if (hit_prog && unlock_reg) begin
                  seq_reg <= ldcr_pkg::SEQ_PROG;
               end
            end
            ldcr_pkg::SEQ_LOAD, ldcr_pkg::SEQ_PROG: begin
               seq_idx_reg <= seq_idx_reg + 3'h1;
               if (seq_last) begin
                  seq_reg <= ldcr_pkg::SEQ_IDLE;
               end
            end
            default: seq_reg <= ldcr_pkg::SEQ_IDLE;
         endcase
      end
   end

   ldcr_nvm ldcr_nvm_inst (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (nvm_we),
      .wr_addr (seq_idx_reg),
      .wr_data (work_reg[seq_idx_reg]),
      .rd_addr (seq_idx_reg),
      .rd_data (nvm_rd_data)
   );

   // ==========================================================
   // working registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_reg[0] <= ldcr_pkg::DEF_SENSE_LEVEL;
         work_reg[1] <= ldcr_pkg::DEF_RAMP_PEAK;
         work_reg[2] <= ldcr_pkg::DEF_FOLDBACK_THRESH;
         work_reg[3] <= ldcr_pkg::DEF_KNEE_POINT;
         work_reg[4] <= ldcr_pkg::DEF_SLOPE_GAIN;
         work_reg[5] <= ldcr_pkg::DEF_CLAMP_LEVEL;
      end else if (ld_valid_reg) begin
         work_reg[ld_idx_reg] <= nvm_rd_data & field_mask(ld_idx_reg);
      end else if (wr_work && seq_idle) begin
         // upper data bits beyond each field are dropped
         work_reg[wr_addr_reg[2:0]] <=
            wr_data_reg[3:0] & field_mask(wr_addr_reg[2:0]);
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense_level_code     <= ldcr_pkg::DEF_SENSE_LEVEL;
         ramp_peak_code       <= ldcr_pkg::DEF_RAMP_PEAK[2:0];
         foldback_thresh_code <= ldcr_pkg::DEF_FOLDBACK_THRESH;
         thermal_knee_code    <= ldcr_pkg::DEF_KNEE_POINT;
         slope_gain_code      <= ldcr_pkg::DEF_SLOPE_GAIN[1:0];
         clamp_level_code     <= ldcr_pkg::DEF_CLAMP_LEVEL[2:0];
         slope_gain_vpv       <= ldcr_pkg::DEF_SLOPE_VPV;
         clamp_percent        <= ldcr_pkg::DEF_CLAMP_PCT;
         knee_mv              <= ldcr_pkg::DEF_KNEE_MV;
         thermal_dim_active   <= 1'b0;
         program_unlocked     <= 1'b0;
         nvm_busy             <= 1'b1;
         sensor_negative_data_pin_o  <= 1'b0;
         sensor_negative_data_pin_oe <= 1'b0;
      end else begin
         sense_level_code     <= work_reg[0];
         ramp_peak_code       <= work_reg[1][2:0];
         foldback_thresh_code <= work_reg[2];
         thermal_knee_code    <= work_reg[3];
         slope_gain_code      <= work_reg[4][1:0];
         clamp_level_code     <= work_reg[5][2:0];
         slope_gain_vpv       <= 5'h10 - {1'b0, work_reg[4][1:0], 2'h0};
         clamp_percent        <= clamp_of(work_reg[5][2:0]);
         knee_mv              <= knee_of(work_reg[3]);
         thermal_dim_active   <= sensor_diff_mv < knee_mv;
         program_unlocked     <= unlock_reg;
         nvm_busy             <= ~seq_idle | ld_valid_reg;
         sensor_negative_data_pin_o  <= 1'b0;
         sensor_negative_data_pin_oe <= sda_oe_reg;
      end
   end

endmodule

//--- tb/ldcr_i2c_master.sv
`timescale 1ns/1ps
module ldcr_i2c_master (
   input  wire logic clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // ===========================================================
   // bit level, one extra clock of hold after every falling clock
   // ===========================================================
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half();
      repeat (9) @(negedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      @(negedge clk);
      sda_low = ~b;
      half();
      scl = 1'b1;
      half();
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      @(negedge clk);
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      @(negedge clk);
      sda_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // ===========================================================
   // transactions
   // ===========================================================
   task automatic xfer(input logic [7:0] dev, input logic [7:0] b [$],
                       output logic ack);
      logic a;
      start();
      put(dev, ack);
      foreach (b[i]) put(b[i], a);
      stop();
   endtask
   task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
      logic a;
      start();
      put(8'hEE, a);
      put(cmd, a);
      start();
      put(8'hEF, a);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, a);
      stop();
   endtask
endmodule

//--- tb/ldcr_top_chk.sv
`timescale 1ns/1ps
module ldcr_top_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        sensor_positive_clock_pin,
   input wire logic [10:0] sensor_diff_mv,
   input wire logic [3:0]  thermal_knee_code,
   input wire logic [1:0]  slope_gain_code,
   input wire logic [2:0]  clamp_level_code,
   input wire logic [4:0]  slope_gain_vpv,
   input wire logic [6:0]  clamp_percent,
   input wire logic [10:0] knee_mv,
   input wire logic        thermal_dim_active,
   input wire logic        program_unlocked,
   input wire logic        nvm_busy
);
   localparam int PCT [8] = '{100, 91, 83, 74, 66, 57, 49, 40};
   localparam int KNEE [16] = '{1174, 1118, 1062, 1006, 950, 894, 838,
      782, 726, 670, 615, 559, 503, 447, 391, 335};
   logic [1:0] up_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         up_reg <= 2'h0;
      end else if (up_reg != 2'h3) begin
         up_reg <= up_reg + 2'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ===========================================================
   // assertions
   // ===========================================================
   AST_GAIN_VPV: assert property ($stable(slope_gain_code) |->
      int'(slope_gain_vpv) == 16 - 4 * int'(slope_gain_code))
      else $error("gain decode wrong");
   AST_CLAMP_PCT: assert property ($stable(clamp_level_code) |->
      int'(clamp_percent) == PCT[clamp_level_code])
      else $error("clamp decode wrong");
   AST_KNEE_MV: assert property ($stable(thermal_knee_code) |->
      int'(knee_mv) == KNEE[thermal_knee_code])
      else $error("knee decode wrong");
   AST_DIM: assert property (up_reg == 2'h3 |-> thermal_dim_active ==
      ($past(sensor_diff_mv) < $past(knee_mv)))
      else $error("dimming flag wrong");
   AST_LOAD_AFTER_RESET: assert property ($rose(rst_n) |->
      ##[1:12] !nvm_busy) else $error("power-up load stuck");
   AST_BUSY_BOUNDED: assert property ($rose(nvm_busy) |->
      ##[1:10] !nvm_busy) else $error("memory sequence too long");
   AST_UNLOCK_WINDOW: assert property ($changed(program_unlocked) |->
      !sensor_positive_clock_pin) else $error("unlock changed off a write");
   AST_GAIN_WINDOW: assert property ($changed(slope_gain_code) |->
      !sensor_positive_clock_pin || nvm_busy || $past(nvm_busy))
      else $error("gain changed without cause");
   cover property ($rose(program_unlocked));
   cover property ($fell(nvm_busy) && program_unlocked);
   cover property ($rose(thermal_dim_active));
endmodule

bind ldcr_top ldcr_top_chk ldcr_top_chk_inst (
   .clk(clk), .rst_n(rst_n),
   .sensor_positive_clock_pin(sensor_positive_clock_pin),
   .sensor_diff_mv(sensor_diff_mv), .thermal_knee_code(thermal_knee_code),
   .slope_gain_code(slope_gain_code), .clamp_level_code(clamp_level_code),
   .slope_gain_vpv(slope_gain_vpv), .clamp_percent(clamp_percent),
   .knee_mv(knee_mv), .thermal_dim_active(thermal_dim_active),
   .program_unlocked(program_unlocked), .nvm_busy(nvm_busy)
);

//--- tb/tb_led_driver_config_registers.sv
`timescale 1ns/1ps
module tb_led_driver_config_registers;
   localparam int FACT [6] = '{15, 7, 0, 0, 3, 7};
   localparam int MSK [6] = '{15, 7, 15, 15, 3, 7};
   localparam int PCT [8] = '{100, 91, 83, 74, 66, 57, 49, 40};
   localparam int KNEE [16] = '{1174, 1118, 1062, 1006, 950, 894, 838,
      782, 726, 670, 615, 559, 503, 447, 391, 335};
   logic        clk = 1'b0;
   logic        rst_n;
   logic        scl;
   logic        sda_low;
   wire         sda;
   logic        sda_o;
   logic        sda_oe;
   logic [10:0] diff;
   logic [3:0]  sense_c;
   logic [2:0]  ramp_c;
   logic [3:0]  thr_c;
   logic [3:0]  knee_c;
   logic [1:0]  gain_c;
   logic [2:0]  clamp_c;
   logic [4:0]  vpv;
   logic [6:0]  pct;
   logic [10:0] knee;
   logic        dim;
   logic        unl_o;
   logic        busy;
   int          work [6];
   int          nvm [6];
   int          unl;
   int          fails = 0;
   int          n_checks = 0;
   integer      seed;
   logic [7:0]  q [$];
   logic [7:0]  d [$];
   logic [7:0]  rb;
   logic        ack;
   // open-drain data wire with pull-up
   assign sda = ~(sda_low | (sda_oe & ~sda_o));
   always #4 clk = ~clk;
   ldcr_top ldcr_top_inst (
      .clk(clk), .rst_n(rst_n), .sensor_positive_clock_pin(scl),
      .sensor_negative_data_pin_i(sda), .sensor_negative_data_pin_o(sda_o),
      .sensor_negative_data_pin_oe(sda_oe), .sensor_diff_mv(diff),
      .sense_level_code(sense_c), .ramp_peak_code(ramp_c),
      .foldback_thresh_code(thr_c), .thermal_knee_code(knee_c),
      .slope_gain_code(gain_c), .clamp_level_code(clamp_c),
      .slope_gain_vpv(vpv), .clamp_percent(pct), .knee_mv(knee),
      .thermal_dim_active(dim), .program_unlocked(unl_o), .nvm_busy(busy)
   );
   ldcr_i2c_master ldcr_i2c_master_inst (
      .clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low)
   );

   // ===========================================================
   // checking
   // ===========================================================
   task automatic test_done();
      if (fails == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [10:0] got, input int exp);
      n_checks++;
      if (got !== 11'(exp)) begin
         fails++;
         $display("unexpected at %0t: got %0d want %0d", $time, got, exp);
      end
   endtask
   task automatic chk_all();
      cmp(11'(sense_c), work[0]);
      cmp(11'(ramp_c), work[1]);
      cmp(11'(thr_c), work[2]);
      cmp(11'(knee_c), work[3]);
      cmp(11'(gain_c), work[4]);
      cmp(11'(clamp_c), work[5]);
      cmp(11'(vpv), 16 - 4 * work[4]);
      cmp(11'(pct), PCT[work[5]]);
      cmp(knee, KNEE[work[3]]);
      cmp(11'(dim), int'(int'(diff) < KNEE[work[3]]));
      cmp(11'(unl_o), unl);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (4) @(negedge clk);
      while (busy !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
      cmp(11'(busy), 0);
   endtask
   task automatic wreg(input logic [7:0] cmd, input logic [7:0] b [$]);
      int a;
      q = b;
      q.push_front(cmd);
      ldcr_i2c_master_inst.xfer(8'hEE, q, ack);
      cmp(11'(ack), 1);
      foreach (b[i]) begin
         a = (int'(cmd) + i > 5) ? 5 : int'(cmd) + i;
         if (cmd <= 8'h05) work[a] = b[i] & MSK[a];
      end
      if (cmd == 8'h06) work = nvm;
      if (cmd == 8'h08 && unl == 1) nvm = work;
      if (cmd == 8'hFF) unl = int'(b[0] == 8'hCA);
      wait_idle();
      chk_all();
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      nvm = FACT;
      work = FACT;
      unl = 0;
      wait_idle();
      chk_all();
   endtask

   // ===========================================================
   // stimulus
   // ===========================================================
   initial begin
      seed = 32'h8B4D;
      rst_n = 1'b0;
      diff = 11'h000;
      do_reset();
      for (int i = 0; i < 16; i++) begin
         diff = 11'(300 + {$random(seed)} % 950);
         d.delete();
         for (int k = 0; k < 7; k++) d.push_back(8'($random(seed)));
         d[3] = {d[3][7:4], 4'(i)};
         d[4] = {d[4][7:2], 2'(i)};
         d[6] = {d[6][7:3], 3'(i)};
         wreg(8'h00, d);
         ldcr_i2c_master_inst.rd(8'(i % 6), rb);
         cmp(11'(rb), work[i % 6]);
      end
      d = '{8'h5A};
      wreg(8'h08, d);
      wreg(8'h06, d);
      d = '{8'h01, 8'h02};
      wreg(8'h04, d);
      d = '{8'h55};
      wreg(8'hFF, d);
      d = '{8'hCA};
      wreg(8'hFF, d);
      d = '{8'h00};
      wreg(8'h08, d);
      d = '{8'hFF, 8'hFF};
      wreg(8'h04, d);
      d = '{8'h77};
      wreg(8'h06, d);
      wreg(8'h07, d);
      ldcr_i2c_master_inst.rd(8'h07, rb);
      cmp(11'(rb), 0);
      d = '{8'h12};
      wreg(8'hFF, d);
      ldcr_i2c_master_inst.xfer(8'hEC, d, ack);
      cmp(11'(ack), 0);
      chk_all();
      do_reset();
      test_done();
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      test_done();
   end
endmodule
